// ===== rtl/scr_defs.svh
// offsets, field positions, reset values and timing counts of the config bank
`ifndef SCR_DEFS_SVH
`define SCR_DEFS_SVH
`define SCR_ADDR_W           12
`define SCR_OFS_GEN_CFG      12'h000
`define SCR_OFS_DEV_MODE     12'h002
`define SCR_OFS_MAKER_LO     12'h00C
`define SCR_OFS_MAKER_HI     12'h00D
`define SCR_OFS_USR_CFG      12'h010
`define SCR_OFS_REF_CTRL     12'h029
`define SCR_OFS_REF_POS0     12'h02C
`define SCR_OFS_REF_POS1     12'h02D
`define SCR_OFS_REF_POS2     12'h02E
`define SCR_BIT_CHIP_RESET   7
`define SCR_BIT_ADDR_INC     5
`define SCR_BIT_SERIAL_OUT_ACTIVE_FLAG   4
`define SCR_BIT_ADDR_FREEZE  0
`define SCR_BIT_PROC_EN      6
`define SCR_BIT_RECV_EN      5
`define SCR_BIT_FINE_STEP    4
`define SCR_RST_GEN_CFG      8'h30
`define SCR_RST_DEV_MODE     8'h00
`define SCR_RST_USR_CFG      8'h00
`define SCR_RST_REF_CTRL     8'h80
`define SCR_GEN_RW_MASK      8'h6F
`define SCR_MODE_POWER_DOWN  2'h3
// arbitrary neutral maker code
`define SCR_MAKER_CODE       16'hC35A
`define SCR_CLK_PERIOD_NS    10
`define SCR_RESET_TIME_NS    750
`define SCR_RESET_CYCLES     ((`SCR_RESET_TIME_NS + `SCR_CLK_PERIOD_NS - 1) / `SCR_CLK_PERIOD_NS)
`endif

// ===== rtl/scr_pkg.sv
// host end state type of the config bank link; both ends import the package
package scr_pkg;
    typedef enum logic [2:0] {
        SCR_H_IDLE  = 3'h1,
        SCR_H_XFER  = 3'h2,
        SCR_H_QUIET = 3'h4
    } scr_hstate_type;
endpackage : scr_pkg

// ===== rtl/scr_link_if.sv
// link between host controller and config bank: byte stream with address
`timescale 1ns/100ps
interface scr_link_if;
    logic        frame;
    logic        wr;
    logic        first;
    logic        valid;
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    modport dev  (input frame, wr, first, valid, addr, wdata, output rdata);
    modport host (output frame, wr, first, valid, addr, wdata, input rdata);
endinterface : scr_link_if

// ===== rtl/scr_dev.sv
// config bank end: registers, streaming address, reset, reference control
`timescale 1ns/100ps
`include "scr_defs.svh"
module scr_dev
    import scr_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    scr_link_if.dev          link,
    input  wire logic [23:0] ref_edge_position_status,
    output logic             power_down,
    output logic             ref_receiver_enable,
    output logic             ref_event_processor_enable,
    output logic             ref_window_fine_step,
    output logic [3:0]       ref_capture_delay_select,
    output logic             chip_reset
);
    typedef struct packed {
        logic [7:0]  gen;
        logic [7:0]  mode;
        logic [7:0]  usr;
        logic [7:0]  ref_ctrl;
        logic [11:0] cur;
        logic [7:0]  rdata;
        logic        creset;
    } scr_dev_state_type;

    scr_dev_state_type s_q, s_d;
    logic [11:0] a;
    logic [7:0]  rd;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_d = s_q;
        s_d.creset = 1'b0;
        a = link.first ? link.addr : s_q.cur;
        case (a)
            `SCR_OFS_GEN_CFG:  rd = s_q.gen | (8'h01 << `SCR_BIT_SERIAL_OUT_ACTIVE_FLAG);
            `SCR_OFS_DEV_MODE: rd = s_q.mode;
            `SCR_OFS_MAKER_LO: rd = 8'(`SCR_MAKER_CODE & 16'h00FF);
            `SCR_OFS_MAKER_HI: rd = 8'(`SCR_MAKER_CODE >> 8);
            `SCR_OFS_USR_CFG:  rd = s_q.usr;
            `SCR_OFS_REF_CTRL: rd = s_q.ref_ctrl;
            `SCR_OFS_REF_POS0: rd = ref_edge_position_status[7:0];
            `SCR_OFS_REF_POS1: rd = ref_edge_position_status[15:8];
            `SCR_OFS_REF_POS2: rd = ref_edge_position_status[23:16];
            default:           rd = 8'h00;
        endcase
        if (link.frame && link.valid) begin
            if (!link.wr) begin
                s_d.rdata = rd;
            end else begin
                case (a)
                    `SCR_OFS_GEN_CFG: begin
                        // flag bit is read-only; reset bit acts, never stores
                        s_d.gen = link.wdata & `SCR_GEN_RW_MASK;
                        s_d.creset = link.wdata[`SCR_BIT_CHIP_RESET];
                    end
                    `SCR_OFS_DEV_MODE: s_d.mode = link.wdata;
                    `SCR_OFS_USR_CFG:  s_d.usr = link.wdata;
                    `SCR_OFS_REF_CTRL: s_d.ref_ctrl = link.wdata;
                    default: ;
                endcase
            end
            if (s_q.usr[`SCR_BIT_ADDR_FREEZE]) begin
                s_d.cur = a;
            end else if (s_q.gen[`SCR_BIT_ADDR_INC]) begin
                s_d.cur = a + 12'h001;
            end else begin
                s_d.cur = a - 12'h001;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q <= '{gen: `SCR_RST_GEN_CFG & `SCR_GEN_RW_MASK, mode: `SCR_RST_DEV_MODE,
                     usr: `SCR_RST_USR_CFG, ref_ctrl: `SCR_RST_REF_CTRL,
                     cur: 12'h000, rdata: 8'h00, creset: 1'b0};
        end else if (s_q.creset) begin
            // whole bank back to defaults; bit itself reads zero again
            s_q <= '{gen: `SCR_RST_GEN_CFG & `SCR_GEN_RW_MASK, mode: `SCR_RST_DEV_MODE,
                     usr: `SCR_RST_USR_CFG, ref_ctrl: `SCR_RST_REF_CTRL,
                     cur: 12'h000, rdata: 8'h00, creset: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign link.rdata = s_q.rdata;
    // reserved codes 1 and 2 fall through to normal operation
    assign power_down = (s_q.mode[1:0] == `SCR_MODE_POWER_DOWN);
    assign ref_receiver_enable = s_q.ref_ctrl[`SCR_BIT_RECV_EN];
    // processor gated by receiver so a wrong order cannot act on noise
    assign ref_event_processor_enable = s_q.ref_ctrl[`SCR_BIT_PROC_EN] & s_q.ref_ctrl[`SCR_BIT_RECV_EN];
    assign ref_window_fine_step = s_q.ref_ctrl[`SCR_BIT_FINE_STEP];
    assign ref_capture_delay_select = s_q.ref_ctrl[3:0];
    assign chip_reset = s_q.creset;
endmodule : scr_dev

// ===== rtl/scr_host.sv
// host controller end: register port in, byte stream out, reset quiet time
`timescale 1ns/100ps
`include "scr_defs.svh"
module scr_host
    import scr_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    scr_link_if.host         link,
    input  wire logic [11:0] cmd_addr,
    input  wire logic [7:0]  cmd_wdata,
    input  wire logic        cmd_wr,
    input  wire logic        cmd_rd,
    output logic [7:0]       cmd_rdata,
    output logic             busy
);
    typedef struct packed {
        scr_hstate_type st;
        logic           frame;
        logic           wr;
        logic           valid;
        logic [11:0]    addr;
        logic [7:0]     wdata;
        logic           rd_pend;
        logic [7:0]     rdata;
        logic [7:0]     cnt;
    } scr_host_state_type;

    scr_host_state_type s_q, s_d;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_d = s_q;
        s_d.valid = 1'b0;
        s_d.frame = 1'b0;
        if (s_q.rd_pend) begin
            s_d.rdata = link.rdata;
            s_d.rd_pend = 1'b0;
        end
        case (s_q.st)
            SCR_H_IDLE: begin
                // commands while quiet are dropped, busy tells software so
                if (cmd_wr || cmd_rd) begin
                    s_d.frame = 1'b1;
                    s_d.valid = 1'b1;
                    s_d.wr = cmd_wr;
                    s_d.addr = cmd_addr;
                    // host keeps read-only and reserved bits at defaults
                    s_d.wdata = (cmd_addr == `SCR_OFS_GEN_CFG) ? (cmd_wdata & 8'hA0) | 8'h10 : cmd_wdata;
                    s_d.st = SCR_H_XFER;
                end
            end
            SCR_H_XFER: begin
                s_d.rd_pend = ~s_q.wr;
                if (s_q.wr && s_q.addr == `SCR_OFS_GEN_CFG && s_q.wdata[`SCR_BIT_CHIP_RESET]) begin
                    s_d.cnt = 8'(`SCR_RESET_CYCLES);
                    s_d.st = SCR_H_QUIET;
                end else begin
                    s_d.st = SCR_H_IDLE;
                end
            end
            SCR_H_QUIET: begin
                s_d.cnt = s_q.cnt - 8'h01;
                if (s_q.cnt == 8'h01) begin
                    s_d.st = SCR_H_IDLE;
                end
            end
            default: s_d.st = SCR_H_IDLE;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q <= '{st: SCR_H_IDLE, frame: 1'b0, wr: 1'b0, valid: 1'b0, addr: 12'h000,
                     wdata: 8'h00, rd_pend: 1'b0, rdata: 8'h00, cnt: 8'h00};
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign link.frame = s_q.frame;
    assign link.wr    = s_q.wr;
    assign link.first = s_q.frame;
    assign link.valid = s_q.valid;
    assign link.addr  = s_q.addr;
    assign link.wdata = s_q.wdata;
    assign cmd_rdata  = s_q.rdata;
    assign busy       = (s_q.st != SCR_H_IDLE);
endmodule : scr_host

// ===== dv/scr_chk.sv
// link checker: spacing, reset quiet time and read values on the wire
`timescale 1ns/100ps
`include "scr_defs.svh"
module scr_chk (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        frame,
    input wire logic        wr,
    input wire logic        first,
    input wire logic        valid,
    input wire logic [11:0] addr,
    input wire logic [7:0]  wdata,
    input wire logic [7:0]  rdata
);
    // distinct bytes so a swapped pair cannot pass
    localparam logic [15:0] MKC = `SCR_MAKER_CODE;
    logic [6:0] qc_q;
    logic [7:0] ref_q;
    logic [1:0] md_q;
    wire        st = frame && valid;
    wire        rd = st && !wr;
    wire        srst = st && wr && addr == `SCR_OFS_GEN_CFG && wdata[7];
    ////////////////////////////////////////////////////////////////
    // shadows of what the wire wrote; soft reset restores them too
    always_ff @(posedge mclk or posedge rst) begin
        if (rst || srst) begin
            qc_q  <= rst ? 7'h00 : 7'h4B;
            ref_q <= 8'h80;
            md_q  <= 2'h0;
        end else begin
            qc_q <= qc_q - {6'h00, qc_q != 7'h00};
            if (st && wr && addr == `SCR_OFS_REF_CTRL) ref_q <= wdata;
            if (st && wr && addr == `SCR_OFS_DEV_MODE) md_q <= wdata[1:0];
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    quiet_after_reset_a: assert property (qc_q != 7'h00 |-> !valid)
        else $error("byte sent during reset wait");
    flag_reads_one_a: assert property (rd && addr == 12'h000 |=> rdata[4] && !rdata[7])
        else $error("general config flags wrong");
    maker_low_a: assert property (rd && addr == 12'h00C |=> rdata == MKC[7:0])
        else $error("maker code low byte wrong");
    maker_high_a: assert property (rd && addr == 12'h00D |=> rdata == MKC[15:8])
        else $error("maker code high byte wrong");
    ref_readback_a: assert property (rd && addr == 12'h029 |=> rdata == $past(ref_q))
        else $error("reference control readback wrong");
    mode_readback_a: assert property (rd && addr == 12'h002 |=> rdata[1:0] == $past(md_q))
        else $error("mode readback wrong");
    rdata_holds_a: assert property (!st && qc_q == 7'h00 |=> $stable(rdata))
        else $error("read data moved without a read");
    byte_gap_a: assert property (st |=> !valid ##1 1'b1)
        else $error("bytes closer than two cycles");
    cover property (srst);
    cover property (rd && addr == 12'h00C);
    cover property (st && wr && addr == 12'h029 && wdata[6]);
endmodule : scr_chk

// ===== dv/spi_config_and_sysref_ctrl_regs_tb.sv
// bench: host and bank joined, command port driven, outputs compared
`timescale 1ns/100ps
`include "scr_defs.svh"
module spi_config_and_sysref_ctrl_regs_tb;
    localparam logic [15:0] MK = `SCR_MAKER_CODE;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [11:0] ca = 12'h000;
    logic [7:0]  cw = 8'h00;
    logic        cwr = 1'b0;
    logic        crd = 1'b0;
    logic [23:0] pos = 24'h000000;
    logic [7:0]  crdata, v;
    logic [3:0]  dsel;
    logic        busy, pd, rx_en, pe_en, fine, crst;
    int          fails = 0;
    int          n_checks = 0;
    int          cyc = 0;
    int          npulse = 0;
    scr_link_if link ();
    scr_host scr_host_i (.mclk(mclk), .rst(rst), .link(link.host), .cmd_addr(ca), .cmd_wdata(cw), .cmd_wr(cwr),
        .cmd_rd(crd), .cmd_rdata(crdata), .busy(busy));
    scr_dev scr_dev_i (.mclk(mclk), .rst(rst), .link(link.dev), .ref_edge_position_status(pos), .power_down(pd),
        .ref_receiver_enable(rx_en), .ref_event_processor_enable(pe_en), .ref_window_fine_step(fine),
        .ref_capture_delay_select(dsel), .chip_reset(crst));
    scr_chk scr_chk_i (.mclk(mclk), .rst(rst), .frame(link.frame), .wr(link.wr), .first(link.first),
        .valid(link.valid), .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata));
    ////////////////////////////////////////////////////////////////
    task automatic conclude();
        if (fails == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask : cmp
    // commands taken while busy are dropped, so always wait it out
    task automatic idle();
        int k;
        k = 0;
        #1;
        while (busy !== 1'b0 && k < 300) begin
            @(posedge mclk);
            #1;
            k++;
        end
        @(posedge mclk);
    endtask : idle
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        ca <= a;
        cw <= d;
        cwr <= 1'b1;
        @(posedge mclk);
        cwr <= 1'b0;
        idle();
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        ca <= a;
        crd <= 1'b1;
        @(posedge mclk);
        crd <= 1'b0;
        repeat (3) @(posedge mclk);
        idle();
        cmp(crdata, e);
    endtask : rd
    // processor output is gated by the receiver enable
    function automatic logic [7:0] outs(input logic [7:0] d);
        return {1'b0, d[6] & d[5], d[5], d[4], d[3:0]};
    endfunction : outs
    ////////////////////////////////////////////////////////////////
    initial begin
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (crst === 1'b1) npulse <= npulse + 1;
        if (cyc == 20000) begin
            fails++;
            conclude();
        end
    end
    initial begin
        v = 8'($urandom(1182));
        pos = 24'($urandom());
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd(12'h000, 8'h30);
        rd(12'h002, 8'h00);
        rd(12'h00C, MK[7:0]);
        rd(12'h00D, MK[15:8]);
        rd(12'h010, 8'h00);
        rd(12'h029, 8'h80);
        rd(12'h02C, pos[7:0]);
        rd(12'h02D, pos[15:8]);
        rd(12'h02E, pos[23:16]);
        rd(12'h7FF, 8'h00);
        wr(12'h00C, 8'h00);
        rd(12'h00C, MK[7:0]);
        for (int m = 0; m < 4; m++) begin
            wr(12'h002, 8'(m));
            cmp({7'h00, pd}, {7'h00, m == 3});
            rd(12'h002, 8'(m));
        end
        for (int i = 0; i < 12; i++) begin
            v = 8'($urandom()) | 8'h80;
            v[6] = v[6] & v[5];
            wr(12'h029, v);
            cmp({1'b0, pe_en, rx_en, fine, dsel}, outs(v));
            rd(12'h029, v);
        end
        wr(12'h010, 8'h01);
        rd(12'h010, 8'h01);
        wr(12'h000, 8'h00);
        rd(12'h000, 8'h10);
        wr(12'h029, 8'hB5);
        wr(12'h000, 8'hB0);
        cmp(8'(npulse), 8'h01);
        rd(12'h000, 8'h30);
        rd(12'h029, 8'h80);
        rd(12'h002, 8'h00);
        rd(12'h010, 8'h00);
        cmp({2'h0, pd, pe_en, rx_en, fine, dsel[1:0]}, 8'h00);
        conclude();
    end
endmodule : spi_config_and_sysref_ctrl_regs_tb
